// ===== logic/sc4_pkg.sv
package sc4_pkg;

   // Counter width and count values
   localparam int         CNT_W     = 4;
   localparam logic [3:0] CNT_ZERO  = 4'h0;   // Cleared count
   localparam logic [3:0] CNT_ONE   = 4'h1;   // Increment step
   localparam logic [3:0] CNT_MAX   = 4'hf;   // Terminal count
   localparam logic [3:0] CNT_RESET = 4'h0;   // Count after RESETN

   // Register bus geometry
   localparam int          APB_AW    = 12;
   localparam int          APB_DW    = 32;
   localparam logic [11:0] ADDR_CTRL = 12'h000;   // Software control
   localparam logic [11:0] ADDR_STAT = 12'h004;   // Counter status

   // Control register fields
   localparam int CTRL_CLR_POS = 0;   // Write 1: clear strobe
   localparam int CTRL_LD_POS  = 1;   // Write 1: load strobe
   localparam int CTRL_PRE_LSB = 4;   // Software preset value

   // Status register fields
   localparam int STAT_CNT_LSB = 0;   // Present count
   localparam int STAT_RCO_POS = 4;   // Ripple carry level
   localparam int STAT_ENT_POS = 5;   // Trickle enable level
   localparam int STAT_ENP_POS = 6;   // Parallel enable level

   // Operation chosen at an edge
   typedef enum logic [1:0] {
      MODE_HOLD,
      MODE_CLEAR,
      MODE_LOAD,
      MODE_COUNT
   } sc4_mode_t;

endpackage : sc4_pkg

// ===== logic/sc4_soft_if.sv
`timescale 1ns/1ns
interface sc4_soft_if;
   logic                        soft_clear;    // One-cycle clear strobe
   logic                        soft_load;     // One-cycle load strobe
   logic [sc4_pkg::CNT_W-1:0]   soft_preset;   // Software preset value
   logic [sc4_pkg::CNT_W-1:0]   count;         // Present count
   logic                        carry;         // Ripple carry level
   logic                        count_enable_trickle;           // Trickle enable level
   logic                        count_enable_parallel;           // Parallel enable level

   // Bus side drives strobes, reads state
   modport bus (output soft_clear, output soft_load, output soft_preset,
                input count, input carry, input count_enable_trickle, input count_enable_parallel);
   // Counter side reads strobes, drives state
   modport core (input soft_clear, input soft_load, input soft_preset,
                 output count, output carry, output count_enable_trickle, output count_enable_parallel);
endinterface : sc4_soft_if

// ===== logic/sc4_ctl_merge.sv
`timescale 1ns/1ns
module sc4_ctl_merge (
   input  wire logic                      zero_n,        // Clear pin, active low
   input  wire logic                      load_n,        // Load pin, active low
   input  wire logic [sc4_pkg::CNT_W-1:0] pin_preset,    // Preset pins
   input  wire logic                      soft_clear,    // Software clear strobe
   input  wire logic                      soft_load,     // Software load strobe
   input  wire logic [sc4_pkg::CNT_W-1:0] soft_preset,   // Software preset
   output logic                           zero_req,      // Clear wanted
   output logic                           load_req,      // Load wanted
   output logic [sc4_pkg::CNT_W-1:0]      load_val       // Value to load
);

   // Pin and software requests combine; the pin preset wins a load tie
   always_comb begin
      zero_req = !zero_n || soft_clear;
      load_req = !load_n || soft_load;
      if (!load_n) begin
         load_val = pin_preset;
      end else begin
         load_val = soft_preset;
      end
   end

endmodule : sc4_ctl_merge

// ===== logic/sc4_apb.sv
`timescale 1ns/1ns
module sc4_apb (
   input  wire logic                        clk,       // Bus clock
   input  wire logic                        rst_n,     // Sync reset, active low
   input  wire logic                        psel,      // Slave select
   input  wire logic                        penable,   // Access phase
   input  wire logic                        pwrite,    // Write direction
   input  wire logic [sc4_pkg::APB_AW-1:0]  paddr,     // Byte address
   input  wire logic [sc4_pkg::APB_DW-1:0]  pwdata,    // Write data
   output logic      [sc4_pkg::APB_DW-1:0]  prdata,    // Read data
   output logic                             pready,    // Transfer done
   output logic                             pslverr,   // Unmapped address
   sc4_soft_if.bus                          sif        // Counter controls
);

   logic                        pready_q, pready_d;       // Answer flag
   logic                        pslverr_q, pslverr_d;     // Error flag
   logic [sc4_pkg::APB_DW-1:0]  prdata_q, prdata_d;       // Read data
   logic [sc4_pkg::CNT_W-1:0]   preset_q, preset_d;       // Software preset
   logic                        clr_q, clr_d;             // Clear strobe
   logic                        ld_q, ld_d;               // Load strobe
   logic                        access;                   // Access phase seen
   logic                        mapped;                   // Address decodes

   // Decode and next values; one wait state, answer on second access cycle
   always_comb begin
      access    = psel && penable;
      mapped    = (paddr == sc4_pkg::ADDR_CTRL) || (paddr == sc4_pkg::ADDR_STAT);
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = '0;
      preset_d  = preset_q;
      clr_d     = 1'b0;
      ld_d      = 1'b0;
      if (access && !pready_q) begin
         // First access cycle: prepare answer
         pready_d  = 1'b1;
         pslverr_d = !mapped;
         if (!pwrite && paddr == sc4_pkg::ADDR_CTRL) begin
            prdata_d[sc4_pkg::CTRL_PRE_LSB +: sc4_pkg::CNT_W] = preset_q;
         end else if (!pwrite && paddr == sc4_pkg::ADDR_STAT) begin
            prdata_d[sc4_pkg::STAT_CNT_LSB +: sc4_pkg::CNT_W] = sif.count;
            prdata_d[sc4_pkg::STAT_RCO_POS]                 = sif.carry;
            prdata_d[sc4_pkg::STAT_ENT_POS]                 = sif.count_enable_trickle;
            prdata_d[sc4_pkg::STAT_ENP_POS]                 = sif.count_enable_parallel;
         end
      end
      if (access && pready_q && pwrite && paddr == sc4_pkg::ADDR_CTRL) begin
         // Write completes at the edge that samples pready high
         preset_d = pwdata[sc4_pkg::CTRL_PRE_LSB +: sc4_pkg::CNT_W];
         clr_d    = pwdata[sc4_pkg::CTRL_CLR_POS];
         ld_d     = pwdata[sc4_pkg::CTRL_LD_POS];
      end
   end

   // Register bus state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
         preset_q  <= sc4_pkg::CNT_RESET;
         clr_q     <= 1'b0;
         ld_q      <= 1'b0;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
         preset_q  <= preset_d;
         clr_q     <= clr_d;
         ld_q      <= ld_d;
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign sif.soft_clear  = clr_q;
   assign sif.soft_load   = ld_q;
   assign sif.soft_preset = preset_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Answer comes one cycle into the access phase and lasts one cycle
   apb_answer_a : assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
      else $error("APB answer timing wrong");
   // Strobe is a single-cycle pulse
   strobe_pulse_a : assert property (clr_q |=> !clr_q)
      else $error("Clear strobe longer than one cycle");

endmodule : sc4_apb

// ===== logic/sc4_top.sv
`timescale 1ns/1ns
module sc4_top (
   input  wire logic                        MCLK,                    // System clock
   input  wire logic                        RESETN,                  // Sync reset, active low
   input  wire logic                        PSEL,                    // APB select
   input  wire logic                        PENABLE,                 // APB access phase
   input  wire logic                        PWRITE,                  // APB direction
   input  wire logic [sc4_pkg::APB_AW-1:0]  PADDR,                   // APB address
   input  wire logic [sc4_pkg::APB_DW-1:0]  PWDATA,                  // APB write data
   output logic      [sc4_pkg::APB_DW-1:0]  PRDATA,                  // APB read data
   output logic                             PREADY,                  // APB ready
   output logic                             PSLVERR,                 // APB error
   input  wire logic                        SYNC_ZERO_N,             // Clear, active low
   input  wire logic                        PRESET_LOAD_N,           // Load, active low
   input  wire logic                        COUNT_ENABLE_PARALLEL,   // Parallel enable
   input  wire logic                        COUNT_ENABLE_TRICKLE,    // Trickle enable
   input  wire logic                        PRESET_BIT0,             // Preset LSB
   input  wire logic                        PRESET_BIT1,             // Preset bit 1
   input  wire logic                        PRESET_BIT2,             // Preset bit 2
   input  wire logic                        PRESET_BIT3,             // Preset MSB
   output logic                             COUNT_BIT0,              // Count LSB
   output logic                             COUNT_BIT1,              // Count bit 1
   output logic                             COUNT_BIT2,              // Count bit 2
   output logic                             COUNT_BIT3,              // Count MSB
   output logic                             RIPPLE_CARRY_OUT         // Terminal count carry
);

   sc4_soft_if                  sif ();                    // Bus to counter link
   logic [sc4_pkg::CNT_W-1:0]   count_q, count_d;          // Count register
   logic [sc4_pkg::CNT_W-1:0]   count_inc;                 // Count plus one
   logic [sc4_pkg::CNT_W-1:0]   pin_preset;                // Preset pins as a word
   logic                        zero_req;                  // Clear wanted
   logic                        load_req;                  // Load wanted
   logic [sc4_pkg::CNT_W-1:0]   load_val;                  // Value to load
   logic                        at_max;                    // Count is fifteen
   sc4_pkg::sc4_mode_t          mode;                      // Operation at this edge

   // Register bus slave
   sc4_apb u_apb (
      .clk     (MCLK),
      .rst_n   (RESETN),
      .psel    (PSEL),
      .penable (PENABLE),
      .pwrite  (PWRITE),
      .paddr   (PADDR),
      .pwdata  (PWDATA),
      .prdata  (PRDATA),
      .pready  (PREADY),
      .pslverr (PSLVERR),
      .sif     (sif.bus)
   );

   // Preset pins packed, bit0 least significant
   assign pin_preset = {PRESET_BIT3, PRESET_BIT2, PRESET_BIT1, PRESET_BIT0};

   // Pin and software requests merged
   sc4_ctl_merge u_merge (
      .zero_n      (SYNC_ZERO_N),
      .load_n      (PRESET_LOAD_N),
      .pin_preset  (pin_preset),
      .soft_clear  (sif.soft_clear),
      .soft_load   (sif.soft_load),
      .soft_preset (sif.soft_preset),
      .zero_req    (zero_req),
      .load_req    (load_req),
      .load_val    (load_val)
   );

   // Mode choice and next count, clear first, then load, then count
   always_comb begin
      count_inc = count_q + sc4_pkg::CNT_ONE;
      if (zero_req) begin
         mode = sc4_pkg::MODE_CLEAR;
      end else if (load_req) begin
         mode = sc4_pkg::MODE_LOAD;
      end else if (COUNT_ENABLE_PARALLEL && COUNT_ENABLE_TRICKLE) begin
         mode = sc4_pkg::MODE_COUNT;
      end else begin
         mode = sc4_pkg::MODE_HOLD;
      end
      case (mode)
         sc4_pkg::MODE_CLEAR: begin
            count_d = sc4_pkg::CNT_ZERO;
         end
         sc4_pkg::MODE_LOAD: begin
            count_d = load_val;
         end
         sc4_pkg::MODE_COUNT: begin
            count_d = count_inc;
         end
         sc4_pkg::MODE_HOLD: begin
            count_d = count_q;
         end
         default: begin
            count_d = count_q;
         end
      endcase
   end

   // All four bits in one register on the rising edge
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         count_q <= sc4_pkg::CNT_RESET;
      end else begin
         count_q <= count_d;
      end
   end

   // Carry look-ahead, gated by trickle enable alone
   assign at_max           = (count_q == sc4_pkg::CNT_MAX);
   assign RIPPLE_CARRY_OUT = COUNT_ENABLE_TRICKLE && at_max;

   // Count outputs straight from the register
   assign COUNT_BIT0 = count_q[0];
   assign COUNT_BIT1 = count_q[1];
   assign COUNT_BIT2 = count_q[2];
   assign COUNT_BIT3 = count_q[3];

   // State shown to the bus
   assign sif.count = count_q;
   assign sif.carry = RIPPLE_CARRY_OUT;
   assign sif.count_enable_trickle   = COUNT_ENABLE_TRICKLE;
   assign sif.count_enable_parallel   = COUNT_ENABLE_PARALLEL;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   // Named steps of a typical sequence
   sequence s_clear;
      zero_req;
   endsequence
   sequence s_load;
      !zero_req && load_req;
   endsequence
   sequence s_count;
      !zero_req && !load_req && COUNT_ENABLE_PARALLEL && COUNT_ENABLE_TRICKLE;
   endsequence
   sequence s_hold;
      !zero_req && !load_req && !(COUNT_ENABLE_PARALLEL && COUNT_ENABLE_TRICKLE);
   endsequence

   clear_zero_a : assert property (s_clear |=> count_q == sc4_pkg::CNT_ZERO)
      else $error("Clear did not zero the count");
   clear_wins_a : assert property (zero_req && load_req |=> count_q == sc4_pkg::CNT_ZERO)
      else $error("Load beat clear");
   load_copy_a : assert property (s_load |=> count_q == $past(load_val))
      else $error("Load did not copy preset");
   pin_load_a : assert property (SYNC_ZERO_N && !PRESET_LOAD_N |=> count_q == $past(pin_preset))
      else $error("Pin preset not loaded");
   count_step_a : assert property (s_count |=> count_q == $past(count_inc))
      else $error("Count did not step by one");
   wrap_zero_a : assert property (s_count and at_max |=> count_q == sc4_pkg::CNT_ZERO)
      else $error("Count did not wrap");
   count_hold_a : assert property (s_hold |=> $stable(count_q))
      else $error("Count moved while disabled");
   load_then_count_a : assert property (s_load ##1 s_count |=> count_q == $past(load_val, 2) + sc4_pkg::CNT_ONE)
      else $error("Count after load wrong");
   carry_level_a : assert property (RIPPLE_CARRY_OUT == (COUNT_ENABLE_TRICKLE && count_q == sc4_pkg::CNT_MAX))
      else $error("Carry level wrong");
   carry_gate_a : assert property (!COUNT_ENABLE_TRICKLE |-> !RIPPLE_CARRY_OUT)
      else $error("Carry high without trickle enable");
   bits_order_a : assert property (COUNT_BIT0 == count_q[0] && COUNT_BIT3 == count_q[3])
      else $error("Count bit order wrong");

endmodule : sc4_top

// ===== testbench/sc4_ctl_model.sv
`timescale 1ns/1ns
// Surrounding control logic: optional lower cascade stage and terminal decode
module sc4_ctl_model (
   input  wire logic                      clk,          // System clock
   input  wire logic                      rst_n,        // Sync reset, active low
   input  wire logic                      cmd_zero_n,   // Commanded clear, active low
   input  wire logic                      cmd_load_n,   // Commanded load, active low
   input  wire logic                      cmd_enp,      // Commanded parallel enable
   input  wire logic                      cmd_ent,      // Commanded trickle enable
   input  wire logic [sc4_pkg::CNT_W-1:0] cmd_preset,   // Commanded preset
   input  wire logic                      cascade_en,   // Gate enables by lower stage carry
   input  wire logic                      trunc_en,     // Decode last count into clear
   input  wire logic [sc4_pkg::CNT_W-1:0] trunc_last,   // Last count when truncating
   input  wire logic [sc4_pkg::CNT_W-1:0] count,        // Counter outputs
   output logic                           zero_n,       // Clear pin
   output logic                           load_n,       // Load pin
   output logic                           count_enable_parallel,          // Parallel enable pin
   output logic                           count_enable_trickle,          // Trickle enable pin
   output logic [sc4_pkg::CNT_W-1:0]      preset        // Preset pins
);
   logic [3:0] low_q;   // Lower stage count
   logic       low_co;  // Lower stage carry

   // Lower stage counts every edge while cascading
   always @(posedge clk) begin
      if (!rst_n) low_q <= 4'h0;
      else if (cascade_en) low_q <= low_q + 4'h1;
   end
   assign low_co = cascade_en ? (low_q == 4'hf) : 1'b1;

   // Carry of lower stage enables this stage
   assign count_enable_parallel    = cmd_enp & low_co;
   assign count_enable_trickle    = cmd_ent & low_co;
   // Decode gate pulls clear low at the chosen last count
   assign zero_n = cmd_zero_n & ~(trunc_en && count == trunc_last);
   assign load_n = cmd_load_n;
   assign preset = cmd_preset;
endmodule : sc4_ctl_model

// ===== testbench/sync_4bit_counter_tb.sv
`timescale 1ns/1ns
module sync_4bit_counter_tb;
   logic        mclk, resetn;                 // Clock and reset
   logic        psel, penable, pwrite;        // APB controls
   logic [11:0] paddr;                        // APB address
   logic [31:0] pwdata, prdata;               // APB data
   logic        pready, pslverr;              // APB answer
   logic        c_zn, c_ln, c_p, c_t;         // Commanded pin controls
   logic [3:0]  c_pre, t_last;                // Commanded preset, truncation point
   logic        casc, trunc;                  // Partner modes
   logic        zero_n, load_n, count_enable_parallel, count_enable_trickle;     // Pin controls at the counter
   logic [3:0]  pre, cnt;                     // Preset and count pins
   logic        ripple_carry_out;                          // Ripple carry
   logic        sw_clr, sw_ld;                // Software strobes seen by reference
   logic [3:0]  sw_pre, exp_cnt;              // Software preset, reference count
   logic [31:0] rd;                           // Read data
   logic        er;                           // Error response
   int          error_cnt, checks, seed;      // Counters and seed

   sc4_top dut (.MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SYNC_ZERO_N(zero_n), .PRESET_LOAD_N(load_n), .COUNT_ENABLE_PARALLEL(count_enable_parallel),
      .COUNT_ENABLE_TRICKLE(count_enable_trickle), .PRESET_BIT0(pre[0]), .PRESET_BIT1(pre[1]), .PRESET_BIT2(pre[2]),
      .PRESET_BIT3(pre[3]), .COUNT_BIT0(cnt[0]), .COUNT_BIT1(cnt[1]), .COUNT_BIT2(cnt[2]),
      .COUNT_BIT3(cnt[3]), .RIPPLE_CARRY_OUT(ripple_carry_out));

   sc4_ctl_model partner (.clk(mclk), .rst_n(resetn), .cmd_zero_n(c_zn), .cmd_load_n(c_ln),
      .cmd_enp(c_p), .cmd_ent(c_t), .cmd_preset(c_pre), .cascade_en(casc), .trunc_en(trunc),
      .trunc_last(t_last), .count(cnt), .zero_n(zero_n), .load_n(load_n), .count_enable_parallel(count_enable_parallel), .count_enable_trickle(count_enable_trickle),
      .preset(pre));

   // Clock
   always #2 mclk = ~mclk;

   // Next count: clear, then load, then count, else hold
   function automatic logic [3:0] next_cnt(input logic [3:0] c, input logic zn, ln, p, t,
                                           input logic [3:0] pv, input logic sc, sl,
                                           input logic [3:0] sp);
      if (!zn || sc) return sc4_pkg::CNT_ZERO;
      if (!ln) return pv;
      if (sl) return sp;
      if (p && t) return c + sc4_pkg::CNT_ONE;
      return c;
   endfunction : next_cnt

   // Compare and report
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // Reference advances on the rising edge only
   always @(posedge mclk) begin
      if (!resetn) exp_cnt <= sc4_pkg::CNT_RESET;
      else exp_cnt <= next_cnt(exp_cnt, zero_n, load_n, count_enable_parallel, count_enable_trickle, pre, sw_clr, sw_ld, sw_pre);
   end

   // Outputs compared mid-cycle, once settled
   always @(negedge mclk) begin
      if (resetn) begin
         check("count", {28'h0, cnt}, {28'h0, exp_cnt});
         check("carry", {31'h0, ripple_carry_out}, {31'h0, count_enable_trickle && exp_cnt == sc4_pkg::CNT_MAX});
      end
   end

   // One cycle of pin controls
   task automatic cyc(input logic zn, ln, p, t, input logic [3:0] pv);
      @(posedge mclk);
      c_zn <= zn; c_ln <= ln; c_p <= p; c_t <= t; c_pre <= pv;
   endtask : cyc

   // APB transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(negedge mclk);
      while (pready !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 50) error_cnt++;
      rd = prdata;
      er = pslverr;
      @(posedge mclk);
      psel <= 1'b0; penable <= 1'b0;
      // Strobes reach the counter one edge after the write
      if (wr && a == sc4_pkg::ADDR_CTRL && er === 1'b0) begin
         sw_clr <= wd[0]; sw_ld <= wd[1]; sw_pre <= wd[7:4];
         @(posedge mclk);
         sw_clr <= 1'b0; sw_ld <= 1'b0;
      end
   endtask : apb

   // Hang guard
   initial begin
      #(4 * 20000);
      error_cnt++;
      end_sim();
   end

   // Main sequence
   initial begin
      mclk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      c_zn = 1; c_ln = 1; c_p = 0; c_t = 0; c_pre = 0; casc = 0; trunc = 0; t_last = 0;
      sw_clr = 0; sw_ld = 0; sw_pre = 0; error_cnt = 0; checks = 0; seed = 32'h57d16aed;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      // Clear, preset 12, count through wrap, inhibit
      cyc(0, 1, 1, 1, 4'h3);
      cyc(1, 0, 1, 1, 4'hc);
      repeat (6) cyc(1, 1, 1, 1, 4'h0);
      repeat (2) cyc(1, 1, 0, 1, 4'h0);
      repeat (2) cyc(1, 1, 1, 0, 4'h0);
      $display("test sequence done");
      // Every preset value, enables in varied levels
      for (int v = 0; v < 16; v++) cyc(1, 0, v[0], ~v[1], v[3:0]);
      cyc(0, 0, 1, 1, 4'h7);
      $display("test load done");
      // Carry gating at fifteen
      cyc(1, 0, 0, 0, 4'hf);
      cyc(1, 1, 1, 0, 4'h0);
      cyc(1, 1, 0, 1, 4'h0);
      $display("test carry done");
      // Shortened length, then cascade
      trunc <= 1'b1; t_last <= 4'h9;
      repeat (25) cyc(1, 1, 1, 1, 4'h0);
      trunc <= 1'b0; casc <= 1'b1;
      repeat (40) cyc(1, 1, 1, 1, 4'h0);
      casc <= 1'b0;
      $display("test cascade done");
      // Random pin traffic
      repeat (300) cyc(($random(seed) & 7) != 0, ($random(seed) & 7) != 0, $random(seed),
                       ($random(seed) & 3) != 0, $random(seed));
      $display("test random done");
      // Software access
      cyc(1, 1, 0, 1, 4'h0);
      apb(1, sc4_pkg::ADDR_CTRL, 32'h000000f2);
      apb(0, sc4_pkg::ADDR_STAT, 32'h0);
      check("stat", rd, 32'h0000003f);
      apb(0, sc4_pkg::ADDR_CTRL, 32'h0);
      check("ctrl", rd, 32'h000000f0);
      apb(1, sc4_pkg::ADDR_CTRL, 32'h00000051);
      apb(1, 12'h00c, 32'h000000a2);
      check("werr", {31'h0, er}, 32'h1);
      apb(0, 12'h008, 32'h0);
      check("rerr", {31'h0, er}, 32'h1);
      check("rdat", rd, 32'h0);
      apb(0, sc4_pkg::ADDR_STAT, 32'h0);
      check("stat", rd, {25'h0, 1'b0, 1'b1, 1'b0, exp_cnt});
      $display("test apb done");
      end_sim();
   end
endmodule : sync_4bit_counter_tb
